// File: rtl/cmd_freq_source_select.sv
// command and frequency source selection for a motor drive
// assumes keypad and modbus commands arrive as one-cycle pulses
// from same-clock logic; terminal pins are resynchronised here
//
// Behaviour
// [RULE1] start taken from selected start source
// [RULE2] stop taken from separate stop source
// [RULE3] codes 2 and 4 accept keypad plus terminal
// [RULE4] both codes 3 means modbus only
// [RULE5] direction is setting xor mode direction
// [RULE6] auto cycle 2 ignores direction setting
// [RULE7] directionless mode uses setting alone
// [RULE8] main source x chosen by code
// [RULE9] mode 0 keeps running frequency after stop
// [RULE10] stored target kept only with memory set
// [RULE11] mode 5 returns to preset after stop
// [RULE12] mode 9 runs from pid output
// [RULE13] secondary source y chosen by code
// [RULE14] y digital loads initial value, alone unsigned
// [RULE15] modes 1,3 use initial polarity, monitored
// [RULE16] analog y scaled by range percentage; code instead caps y at that percentage of x or max_freq
// [RULE17] pot y allows only x 4 or 10
// [RULE18] same source for x and y: x only
// [RULE19] combination 0 x, 1 x+y, 5 x-y
// [RULE20] mode 2 switches x/y, 3 x/x+y
// [RULE21] mode 4 stage speed beats analog
// [RULE22] combined uses general ramps, stage own
// [RULE23] terminal scheme nonzero voids source settings
// [RULE24] combined result clamped to zero..max
`timescale 1ns/1ps
module cmd_freq_source_select
  import cmd_src_pkg::*;
#(
  parameter int FW = 16
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // command pulses from same-clock logic
  input wire cmd_pair_t keypad_cmd_i,
  input wire cmd_pair_t modbus_cmd_i,
  // raw terminal pins
  input wire logic term_start_i,
  input wire logic term_stop_i,
  input wire logic src_switch_i,
  input wire logic updown_up_i,
  input wire logic updown_dn_i,
  // mode context
  input wire logic mode_dir_i,
  input wire logic mode_has_dir_i,
  input wire logic stage_active_i,
  input wire logic [15:0] auto_cycle_select_i,
  input wire logic [15:0] terminal_run_scheme_i,
  input wire logic power_up_i,
  input wire logic [FW-1:0] run_freq_i,
  input wire freq_in_t freq_i,
  // results
  output logic run_o,
  output logic dir_o,
  output logic [FW-1:0] target_o,
  output logic use_general_ramp_o,
  output logic cfg_error_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] start_source_sel;
    logic [15:0] stop_source_sel;
    logic dir_set;
    logic [15:0] main_freq_source_sel;
    logic [15:0] secondary_freq_source_sel;
    logic range_ref;
    logic [15:0] range_pct;
    logic [15:0] comb_sel;
    logic [15:0] preset_target_frequency;
    logic [2:0] misc;
    logic [15:0] secondary_initial_value;
    logic [15:0] max_freq;
    logic [1:0] ts_m;     // first stage, read only by second
    logic [1:0] ts;       // terminal start/stop synced
    logic [2:0] sw_m;     // switch, up, down first stage
    logic [2:0] sw;
    logic [2:0] sw_p;     // previous for edges
    logic [FW-1:0] dig;   // digital target
    logic [FW-1:0] y_dig; // secondary digital value
    logic y_pol;
    logic run;
    logic dir;
    logic [FW-1:0] target;
    logic gen_ramp;
    logic err;
    logic [31:0] dat;
    logic ack;
  } state_t;

  state_t s_q, s_d;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // percentage of a reference, result is frequency width
  function automatic logic [FW-1:0] pct_of(input logic [FW-1:0] ref_v,
                                           input logic [15:0] pct);
    logic [FW+15:0] prod;
    prod = ref_v * pct;
    return FW'(prod / PCT_FULL);
  endfunction

  // selects a raw source by frequency code
  function automatic logic [FW-1:0] src_val(input logic [15:0] code,
                                            input logic [FW-1:0] dig_v,
                                            input freq_in_t f);
    logic [FW-1:0] v;
    v = '0;
    unique case (code)
      FS_DIG_MEM, FS_DIG_NOMEM: v = dig_v;
      FS_AIN1: v = FW'(f.ain1);
      FS_AIN2: v = FW'(f.ain2);
      FS_STAGE: v = FW'(f.stage);
      FS_PID: v = FW'(f.pid);
      FS_MODBUS: v = FW'(f.modbus);
      default: v = '0;
    endcase
    return v;
  endfunction

  // command source accepts keypad / terminal / modbus
  function automatic logic [2:0] src_mask(input logic [15:0] code);
    logic [2:0] m;
    m = 3'h0;
    unique case (code)
      CS_KEYPAD: m = 3'h1;
      CS_TERM: m = 3'h2;
      CS_KEY_TERM: m = 3'h3;
      CS_MODBUS: m = 3'h4;
      CS_ALL: m = 3'h7;
      default: m = 3'h0;
    endcase
    return m;
  endfunction

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic [2:0] smask;
    logic [2:0] pmask;
    logic start_ev;
    logic stop_ev;
    logic scheme_on;
    logic [FW-1:0] x;
    logic [FW-1:0] y;
    logic [FW-1:0] yraw;
    logic [FW+1:0] sum;
    logic y_same;
    logic y_analog;
    logic [15:0] ysrc;
    logic [FW-1:0] tgt;
    logic comb;
    logic up_ev;
    logic dn_ev;
    logic wr;
    s_d = s_q;
    smask = src_mask(s_q.start_source_sel);
    pmask = src_mask(s_q.stop_source_sel);
    scheme_on = (terminal_run_scheme_i != RST_ZERO);
    // [RULE23] scheme overrides
    if (scheme_on) begin
      smask = 3'h2;
      pmask = 3'h2;
    end
    // [RULE1] [RULE3] start gating
    start_ev = (smask[0] & keypad_cmd_i.start) | (smask[1] & s_q.ts[1])
             | (smask[2] & modbus_cmd_i.start);
    // [RULE2] [RULE4] stop gating
    stop_ev = (pmask[0] & keypad_cmd_i.stop) | (pmask[1] & s_q.ts[0])
            | (pmask[2] & modbus_cmd_i.stop);
    up_ev = s_q.sw[1] & ~s_q.sw_p[1];
    dn_ev = s_q.sw[2] & ~s_q.sw_p[2];

    // synchronisers and edge history
    s_d.ts_m = {term_start_i, term_stop_i};
    s_d.ts = s_q.ts_m;
    s_d.sw_m = {updown_dn_i, updown_up_i, src_switch_i};
    s_d.sw = s_q.sw_m;
    s_d.sw_p = s_q.sw;

    // run flag, stop wins
    if (stop_ev) begin
      s_d.run = 1'b0;
    end else if (start_ev) begin
      s_d.run = 1'b1;
    end

    // direction
    if (scheme_on) begin
      // terminal scheme supplies direction itself
      s_d.dir = mode_dir_i;
    end else if (auto_cycle_select_i == AUTO_CYCLE_IGN_DIR) begin
      // [RULE6] setting ignored
      s_d.dir = mode_dir_i;
    end else if (!mode_has_dir_i) begin
      // [RULE7] setting alone
      s_d.dir = s_q.dir_set;
    end else begin
      // [RULE5] xor of both
      s_d.dir = s_q.dir_set ^ mode_dir_i;
    end

    // [RULE9] up/down stepping of the digital target
    if (up_ev && s_q.dig != s_q.max_freq) begin
      s_d.dig = s_q.dig + FW'(1);
    end else if (dn_ev && s_q.dig != '0) begin
      s_d.dig = s_q.dig - FW'(1);
    end
    if (s_q.run && stop_ev) begin
      if (s_q.main_freq_source_sel == FS_DIG_NOMEM) begin
        // [RULE11] back to preset
        s_d.dig = FW'(s_q.preset_target_frequency);
      end else begin
        // [RULE9] keep last running frequency
        s_d.dig = run_freq_i;
      end
    end
    // [RULE10] power loss memory
    if (power_up_i && !s_q.misc[MISC_MEM_BIT]) begin
      s_d.dig = FW'(s_q.preset_target_frequency);
    end

    // [RULE8] [RULE12] main source x
    x = src_val(s_q.main_freq_source_sel, s_q.dig, freq_i);
    // [RULE13] [RULE14] secondary source y
    ysrc = s_q.secondary_freq_source_sel;
    y_analog = (ysrc == FS_AIN1) || (ysrc == FS_AIN2);
    yraw = (ysrc == FS_Y_PID) ? FW'(freq_i.pid)
         : src_val(ysrc, s_q.y_dig, freq_i);
    // [RULE16] range scaling
    if (y_analog) begin
      y = pct_of(s_q.range_ref ? x : s_q.max_freq,
                 (s_q.range_pct > PCT_FULL) ? PCT_FULL : s_q.range_pct);
      // range is a ceiling on the analog value, not a gain
      y = (yraw > y) ? y : yraw;
    end else begin
      y = yraw;
    end
    // [RULE18] shared channel, x only
    y_same = (ysrc == s_q.main_freq_source_sel) && (ysrc != FS_Y_PID);
    // [RULE17] pot y needs x stage or modbus
    s_d.err = y_same
      | (s_q.misc[MISC_POT_Y_BIT] && s_q.main_freq_source_sel != FS_STAGE
         && s_q.main_freq_source_sel != FS_MODBUS);

    // [RULE15] digital y value and polarity from initial settings
    if (ysrc == FS_DIG_MEM) begin
      s_d.y_dig = FW'(s_q.secondary_initial_value);
      s_d.y_pol = s_q.misc[MISC_SEC_POL_BIT];
    end

    // [RULE19] [RULE20] [RULE21] [RULE24] combination
    comb = 1'b1;
    sum = {2'b00, x};
    unique case (s_q.comb_sel)
      CB_X: begin
        sum = {2'b00, x};
        comb = 1'b0;
      end
      CB_XPY: begin
        sum = (ysrc == FS_DIG_MEM && s_q.y_pol) ? {2'b00, x} - {2'b00, y}
            : {2'b00, x} + {2'b00, y};
      end
      CB_X_OR_Y: begin
        // [RULE14] y alone ignores polarity
        sum = s_q.sw[0] ? {2'b00, y} : {2'b00, x};
      end
      CB_X_OR_XPY: begin
        sum = !s_q.sw[0] ? {2'b00, x}
            : (ysrc == FS_DIG_MEM && s_q.y_pol) ? {2'b00, x} - {2'b00, y}
            : {2'b00, x} + {2'b00, y};
      end
      CB_STAGE_AIN: begin
        // [RULE22] stage speed in force keeps own ramps
        comb = ~stage_active_i;
        sum = stage_active_i ? {2'b00, x} : {2'b00, y};
      end
      CB_XMY: begin
        sum = {2'b00, x} - {2'b00, y};
      end
      default: begin
        sum = {2'b00, x};
        comb = 1'b0;
      end
    endcase
    if (y_same) begin
      sum = {2'b00, x};
    end
    // [RULE24] clamp to range
    if (sum[FW+1]) begin
      tgt = '0;
    end else if (sum[FW:0] > {1'b0, s_q.max_freq}) begin
      tgt = s_q.max_freq;
    end else begin
      tgt = sum[FW-1:0];
    end
    s_d.target = tgt;
    // [RULE22] ramp choice
    s_d.gen_ramp = comb | (s_q.main_freq_source_sel != FS_STAGE);

    // wishbone, ack one cycle
    wr = wb_i.cyc && wb_i.stb && wb_i.we && !s_q.ack;
    s_d.ack = wb_i.cyc && wb_i.stb && !s_q.ack;
    s_d.dat = 32'h0;
    if (wr && wb_i.sel[0] && wb_i.sel[1]) begin
      unique case (wb_i.adr)
        OFS_START_SRC: s_d.start_source_sel = wb_i.dat[15:0];
        OFS_STOP_SRC: s_d.stop_source_sel = wb_i.dat[15:0];
        OFS_DIR_SET: s_d.dir_set = wb_i.dat[0];
        OFS_MAIN_SRC: s_d.main_freq_source_sel = wb_i.dat[15:0];
        OFS_SEC_SRC: s_d.secondary_freq_source_sel = wb_i.dat[15:0];
        OFS_RANGE_REF: s_d.range_ref = wb_i.dat[0];
        OFS_RANGE_PCT: s_d.range_pct = wb_i.dat[15:0];
        OFS_COMB_SEL: s_d.comb_sel = wb_i.dat[15:0];
        OFS_PRESET_FREQ: s_d.preset_target_frequency = wb_i.dat[15:0];
        OFS_MISC_CFG: s_d.misc = wb_i.dat[2:0];
        OFS_SEC_INIT: s_d.secondary_initial_value = wb_i.dat[15:0];
        OFS_MAX_FREQ: s_d.max_freq = FW'(wb_i.dat[15:0]);
        default: s_d.ack = s_d.ack;
      endcase
    end
    unique case (wb_i.adr)
      OFS_START_SRC: s_d.dat = {16'h0, s_q.start_source_sel};
      OFS_STOP_SRC: s_d.dat = {16'h0, s_q.stop_source_sel};
      OFS_DIR_SET: s_d.dat = {31'h0, s_q.dir_set};
      OFS_MAIN_SRC: s_d.dat = {16'h0, s_q.main_freq_source_sel};
      OFS_SEC_SRC: s_d.dat = {16'h0, s_q.secondary_freq_source_sel};
      OFS_RANGE_REF: s_d.dat = {31'h0, s_q.range_ref};
      OFS_RANGE_PCT: s_d.dat = {16'h0, s_q.range_pct};
      OFS_COMB_SEL: s_d.dat = {16'h0, s_q.comb_sel};
      OFS_PRESET_FREQ: s_d.dat = {16'h0, s_q.preset_target_frequency};
      OFS_MISC_CFG: s_d.dat = {29'h0, s_q.misc};
      OFS_SEC_INIT: s_d.dat = {16'h0, s_q.secondary_initial_value};
      OFS_MAX_FREQ: s_d.dat = 32'(s_q.max_freq);
      // [RULE15] value and polarity monitor
      OFS_SEC_MON: s_d.dat = {s_q.y_pol, 15'h0, 16'(s_q.y_dig)};
      OFS_STATUS: s_d.dat = {28'h0, s_q.err, s_q.gen_ramp, s_q.dir, s_q.run};
      OFS_TARGET: s_d.dat = 32'(s_q.target);
      default: s_d.dat = 32'h0;
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.start_source_sel <= RST_SRC_SEL;
      s_q.stop_source_sel <= RST_SRC_SEL;
      s_q.range_pct <= RST_RANGE_PCT;
      s_q.max_freq <= '1;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign run_o = s_q.run;
  assign dir_o = s_q.dir;
  assign target_o = s_q.target;
  assign use_general_ramp_o = s_q.gen_ramp;
  assign cfg_error_o = s_q.err;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_modbus_only;
    ce_i && terminal_run_scheme_i == RST_ZERO && s_q.start_source_sel == CS_MODBUS
      && !s_q.run && !modbus_cmd_i.start |=> !s_q.run;
  endproperty
  a_modbus_only: assert property (p_modbus_only) else $error("non modbus start"); // [RULE4]

  property p_keypad_start;
    ce_i && terminal_run_scheme_i == RST_ZERO && s_q.start_source_sel == CS_ALL
      && keypad_cmd_i.start && !keypad_cmd_i.stop && !modbus_cmd_i.stop
      && !s_q.ts[0] |=> s_q.run;
  endproperty
  a_keypad_start: assert property (p_keypad_start) else $error("keypad start lost"); // [RULE1]

  property p_stop;
    ce_i && terminal_run_scheme_i == RST_ZERO && s_q.stop_source_sel == CS_ALL
      && modbus_cmd_i.stop |=> !s_q.run;
  endproperty
  a_stop: assert property (p_stop) else $error("stop lost"); // [RULE2]

  property p_dir_xor;
    ce_i && terminal_run_scheme_i == RST_ZERO && auto_cycle_select_i != AUTO_CYCLE_IGN_DIR
      && mode_has_dir_i |=> s_q.dir == ($past(s_q.dir_set) ^ $past(mode_dir_i));
  endproperty
  a_dir_xor: assert property (p_dir_xor) else $error("direction wrong"); // [RULE5]

  property p_dir_auto;
    ce_i && auto_cycle_select_i == AUTO_CYCLE_IGN_DIR |=> s_q.dir == $past(mode_dir_i);
  endproperty
  a_dir_auto: assert property (p_dir_auto) else $error("setting not ignored"); // [RULE6]

  property p_clamp;
    s_q.target <= s_q.max_freq || $past(s_q.max_freq) != s_q.max_freq;
  endproperty
  a_clamp: assert property (p_clamp) else $error("target above max"); // [RULE24]

  property p_only_x;
    ce_i && s_q.comb_sel == CB_X && !s_q.err |=> s_q.target ==
      ($past(src_val(s_q.main_freq_source_sel, s_q.dig, freq_i)) > $past(s_q.max_freq)
       ? $past(s_q.max_freq) : $past(src_val(s_q.main_freq_source_sel, s_q.dig, freq_i)));
  endproperty
  a_only_x: assert property (p_only_x) else $error("x alone wrong"); // [RULE19]

  property p_ack;
    wb_i.cyc && wb_i.stb && !s_q.ack && ce_i |=> s_q.ack ##1 !s_q.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing"); // wishbone ack one cycle

endmodule

// File: shared/cmd_src_pkg.sv
// package for the command and frequency source selection block
// assumes a classic wishbone slave with 32-bit data, 125 MHz clock
package cmd_src_pkg;

  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_START_SRC = 8'h00;
  localparam logic [7:0] OFS_STOP_SRC = 8'h04;
  localparam logic [7:0] OFS_DIR_SET = 8'h08;
  localparam logic [7:0] OFS_MAIN_SRC = 8'h0c;
  localparam logic [7:0] OFS_SEC_SRC = 8'h10;
  localparam logic [7:0] OFS_RANGE_REF = 8'h14;
  localparam logic [7:0] OFS_RANGE_PCT = 8'h18;
  localparam logic [7:0] OFS_COMB_SEL = 8'h1c;
  localparam logic [7:0] OFS_PRESET_FREQ = 8'h20;
  localparam logic [7:0] OFS_MISC_CFG = 8'h24;
  localparam logic [7:0] OFS_SEC_INIT = 8'h28;
  localparam logic [7:0] OFS_MAX_FREQ = 8'h2c;
  localparam logic [7:0] OFS_SEC_MON = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  localparam logic [7:0] OFS_TARGET = 8'h38;

  // --------------------------------------------------------------
  // reset values and codes
  // --------------------------------------------------------------
  localparam logic [15:0] RST_SRC_SEL = 16'h0004;
  localparam logic [15:0] RST_RANGE_PCT = 16'h0064;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] PCT_FULL = 16'h0064;

  // command source codes
  localparam logic [15:0] CS_KEYPAD = 16'h0000;
  localparam logic [15:0] CS_TERM = 16'h0001;
  localparam logic [15:0] CS_KEY_TERM = 16'h0002;
  localparam logic [15:0] CS_MODBUS = 16'h0003;
  localparam logic [15:0] CS_ALL = 16'h0004;

  // frequency source codes
  localparam logic [15:0] FS_DIG_MEM = 16'h0000;
  localparam logic [15:0] FS_AIN1 = 16'h0001;
  localparam logic [15:0] FS_AIN2 = 16'h0002;
  localparam logic [15:0] FS_STAGE = 16'h0004;
  localparam logic [15:0] FS_DIG_NOMEM = 16'h0005;
  localparam logic [15:0] FS_PID = 16'h0009;
  localparam logic [15:0] FS_MODBUS = 16'h000a;
  localparam logic [15:0] FS_Y_PID = 16'h0005;

  // combination codes
  localparam logic [15:0] CB_X = 16'h0000;
  localparam logic [15:0] CB_XPY = 16'h0001;
  localparam logic [15:0] CB_X_OR_Y = 16'h0002;
  localparam logic [15:0] CB_X_OR_XPY = 16'h0003;
  localparam logic [15:0] CB_STAGE_AIN = 16'h0004;
  localparam logic [15:0] CB_XMY = 16'h0005;

  localparam logic [15:0] AUTO_CYCLE_IGN_DIR = 16'h0002;

  // misc config bit positions
  localparam int MISC_MEM_BIT = 0;
  localparam int MISC_SEC_POL_BIT = 1;
  localparam int MISC_POT_Y_BIT = 2;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic start;
    logic stop;
  } cmd_pair_t;

  typedef struct packed {
    logic [15:0] stage;
    logic [15:0] ain1;
    logic [15:0] ain2;
    logic [15:0] pid;
    logic [15:0] modbus;
  } freq_in_t;

endpackage

// File: tb/cmd_partner.sv
// partner model: keypad, control terminal pins and a modbus master
// assumes the bench calls send from the clock domain of the block
`timescale 1ns/1ps
module cmd_partner
  import cmd_src_pkg::*;
(
  // clock
  input wire logic clk_i,
  // command sources
  output cmd_pair_t keypad_cmd_o,
  output cmd_pair_t modbus_cmd_o,
  output logic term_start_o,
  output logic term_stop_o
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    keypad_cmd_o = '0;
    modbus_cmd_o = '0;
    term_start_o = 1'b0;
    term_stop_o = 1'b0;
  end

  // one command: src 0 keypad, 1 terminal, 2 modbus
  task automatic send(input int src, input logic stop);
    cmd_pair_t p;
    p = stop ? 2'b01 : 2'b10;
    @(posedge clk_i);
    case (src)
      0: keypad_cmd_o <= p;
      1: begin
        term_start_o <= ~stop;
        term_stop_o <= stop;
      end
      default: modbus_cmd_o <= p;
    endcase
    // pins held past the resync flops, pulses last one cycle
    repeat (src == 1 ? 4 : 1) @(posedge clk_i);
    keypad_cmd_o <= '0;
    modbus_cmd_o <= '0;
    term_start_o <= 1'b0;
    term_stop_o <= 1'b0;
  endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the command and frequency source selection
// assumes a 125 MHz clock and a classic wishbone register bus
`timescale 1ns/1ps
module testbench;
  import cmd_src_pkg::*;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t wb_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  cmd_pair_t keypad_cmd;
  cmd_pair_t modbus_cmd;
  logic term_start;
  logic term_stop;
  logic src_switch_i = 1'b0; // x/y switch terminal
  logic updown_up_i = 1'b0;
  logic power_up_i = 1'b0;
  logic [15:0] run_freq_i = '0;
  logic mode_dir_i = 1'b0;
  logic mode_has_dir_i = 1'b0;
  logic stage_active_i = 1'b0;
  logic [15:0] auto_cycle_select_i = '0;
  logic [15:0] terminal_run_scheme_i = '0;
  freq_in_t freq_i = '{16'h0300, 16'h0120, 16'h0040, 16'h0500, 16'h0a00};
  logic run_o;
  logic dir_o;
  logic use_general_ramp_o;
  logic cfg_error_o;
  logic [15:0] target_o;
  logic [31:0] rd; // last read data
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #4 clk_i = ~clk_i;

  // ----------------------------------------
  // block and partner
  // ----------------------------------------
  cmd_freq_source_select u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_i(wb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .keypad_cmd_i(keypad_cmd),
    .modbus_cmd_i(modbus_cmd), .term_start_i(term_start), .term_stop_i(term_stop),
    .src_switch_i(src_switch_i), .updown_up_i(updown_up_i), .updown_dn_i(1'b0),
    .mode_dir_i(mode_dir_i), .mode_has_dir_i(mode_has_dir_i),
    .stage_active_i(stage_active_i), .auto_cycle_select_i(auto_cycle_select_i),
    .terminal_run_scheme_i(terminal_run_scheme_i), .power_up_i(power_up_i),
    .run_freq_i(run_freq_i), .freq_i(freq_i), .run_o(run_o), .dir_o(dir_o),
    .target_o(target_o), .use_general_ramp_o(use_general_ramp_o),
    .cfg_error_o(cfg_error_o));
  cmd_partner u_partner (.clk_i(clk_i), .keypad_cmd_o(keypad_cmd),
    .modbus_cmd_o(modbus_cmd), .term_start_o(term_start), .term_stop_o(term_stop));

  // ----------------------------------------
  // bus and helpers
  // ----------------------------------------
  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hf, adr:a, dat:d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_i <= '0;
    if (n >= 50) `CHK("ack", 1'b1, 1'b0)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask

  // command through the partner, then run level
  task automatic cmd(input string n, input int src, input logic stop, input logic e);
    u_partner.send(src, stop);
    repeat (2) @(posedge clk_i);
    `CHK(n, e, run_o)
  endtask

  // program x, y and combination, then target
  task automatic tgt(input string n, input logic [15:0] x, y, c, e);
    wr(OFS_MAIN_SRC, {16'h0, x});
    wr(OFS_SEC_SRC, {16'h0, y});
    wr(OFS_COMB_SEL, {16'h0, c});
    repeat (4) @(posedge clk_i);
    `CHK(n, e, target_o)
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdchk("start src", OFS_START_SRC, 32'h4);
    rdchk("stop src", OFS_STOP_SRC, 32'h4);
    rdchk("main src", OFS_MAIN_SRC, 32'h0);
    rdchk("sec src", OFS_SEC_SRC, 32'h0);
    rdchk("range ref", OFS_RANGE_REF, 32'h0);
    rdchk("range pct", OFS_RANGE_PCT, 32'h64);
    rdchk("comb", OFS_COMB_SEL, 32'h0);
    rdchk("unmapped", 8'h3c, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_cmd;
    wr(OFS_START_SRC, 32'h0);
    wr(OFS_STOP_SRC, 32'h0);
    cmd("modbus start", 2, 1'b0, 1'b0);
    cmd("keypad start", 0, 1'b0, 1'b1);
    cmd("term stop", 1, 1'b1, 1'b1);
    cmd("keypad stop", 0, 1'b1, 1'b0);
    wr(OFS_START_SRC, 32'h2);
    wr(OFS_STOP_SRC, 32'h2);
    cmd("term start", 1, 1'b0, 1'b1);
    cmd("keypad stop", 0, 1'b1, 1'b0);
    wr(OFS_START_SRC, 32'h3);
    wr(OFS_STOP_SRC, 32'h3);
    cmd("keypad start", 0, 1'b0, 1'b0);
    cmd("term start", 1, 1'b0, 1'b0);
    cmd("modbus start", 2, 1'b0, 1'b1);
    cmd("modbus stop", 2, 1'b1, 1'b0);
    wr(OFS_START_SRC, 32'h4);
    wr(OFS_STOP_SRC, 32'h4);
    cmd("modbus start", 2, 1'b0, 1'b1);
    cmd("keypad stop", 0, 1'b1, 1'b0);
    // terminal scheme voids the keypad source
    terminal_run_scheme_i <= 16'h1;
    cmd("scheme keypad", 0, 1'b0, 1'b0);
    terminal_run_scheme_i <= 16'h0;
    $display("test commands done");
  endtask

  task automatic t_dir;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DIR_SET, 32'(i >> 1));
      mode_dir_i <= i[0];
      mode_has_dir_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("dir xor", i[1] ^ i[0], dir_o)
      mode_has_dir_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK("dir setting", i[1], dir_o)
      auto_cycle_select_i <= 16'h2;
      mode_has_dir_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("dir auto", i[0], dir_o)
      auto_cycle_select_i <= 16'h0;
    end
    $display("test direction done");
  endtask

  task automatic t_freq;
    tgt("x ain1", FS_AIN1, FS_AIN2, CB_X, 16'h0120);
    tgt("x ain2", FS_AIN2, FS_AIN1, CB_X, 16'h0040);
    tgt("x pid", FS_PID, FS_AIN1, CB_X, 16'h0500);
    tgt("x modbus", FS_MODBUS, FS_AIN1, CB_X, 16'h0a00);
    tgt("x plus y", FS_AIN1, FS_AIN2, CB_XPY, 16'h0160);
    `CHK("ramp", 1'b1, use_general_ramp_o)
    tgt("x minus y", FS_AIN1, FS_AIN2, CB_XMY, 16'h00e0);
    tgt("negative", FS_AIN2, FS_AIN1, CB_XMY, 16'h0000);
    tgt("same src", FS_AIN1, FS_AIN1, CB_XPY, 16'h0120);
    `CHK("cfg error", 1'b1, cfg_error_o)
    src_switch_i <= 1'b1;
    tgt("switch y", FS_AIN1, FS_AIN2, CB_X_OR_Y, 16'h0040);
    tgt("switch x+y", FS_AIN1, FS_AIN2, CB_X_OR_XPY, 16'h0160);
    src_switch_i <= 1'b0;
    tgt("switch x", FS_AIN1, FS_AIN2, CB_X_OR_Y, 16'h0120);
    stage_active_i <= 1'b1;
    tgt("stage", FS_STAGE, FS_AIN1, CB_STAGE_AIN, 16'h0300);
    `CHK("stage ramp", 1'b0, use_general_ramp_o)
    stage_active_i <= 1'b0;
    tgt("analog", FS_STAGE, FS_AIN1, CB_STAGE_AIN, 16'h0120);
    `CHK("analog ramp", 1'b1, use_general_ramp_o)
    // secondary digital value and polarity from initial settings
    wr(OFS_SEC_INIT, 32'h10);
    tgt("y init", FS_AIN1, FS_DIG_MEM, CB_XPY, 16'h0130);
    wr(OFS_MISC_CFG, 32'h2);
    tgt("y negative", FS_AIN1, FS_DIG_MEM, CB_XPY, 16'h0110);
    rdchk("monitor", OFS_SEC_MON, 32'h80000010);
    wr(OFS_RANGE_PCT, 32'h0);
    tgt("pct zero", FS_AIN1, FS_AIN2, CB_XPY, 16'h0120);
    wr(OFS_RANGE_PCT, 32'h64);
    wr(OFS_MAX_FREQ, 32'h150);
    tgt("max clamp", FS_AIN1, FS_AIN2, CB_XPY, 16'h0150);
    $display("test frequency done");
  endtask

  task automatic t_dig;
    tgt("dig start", FS_DIG_MEM, FS_AIN1, CB_X, 16'h0000);
    updown_up_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK("dig up", 16'h0001, target_o)
    updown_up_i <= 1'b0;
    wr(OFS_PRESET_FREQ, 32'h30);
    power_up_i <= 1'b1;
    @(posedge clk_i);
    power_up_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("no memory", 16'h0030, target_o)
    wr(OFS_MISC_CFG, 32'h1);
    run_freq_i <= 16'h0088;
    cmd("dig run", 0, 1'b0, 1'b1);
    cmd("dig stop", 0, 1'b1, 1'b0);
    `CHK("last run", 16'h0088, target_o)
    power_up_i <= 1'b1;
    @(posedge clk_i);
    power_up_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("memory kept", 16'h0088, target_o)
    wr(OFS_MAIN_SRC, {16'h0, FS_DIG_NOMEM});
    cmd("nomem run", 0, 1'b0, 1'b1);
    cmd("nomem stop", 0, 1'b1, 1'b0);
    `CHK("preset", 16'h0030, target_o)
    wr(OFS_MISC_CFG, 32'h5);
    repeat (2) @(posedge clk_i);
    `CHK("pot y", 1'b1, cfg_error_o)
    tgt("pot y modbus", FS_MODBUS, FS_AIN1, CB_X, 16'h0150);
    `CHK("pot y ok", 1'b0, cfg_error_o)
    $display("test digital done");
  endtask

  // ----------------------------------------
  // verdict and run control
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_cmd();
    t_dir();
    t_freq();
    t_dig();
    results();
  end
endmodule
